// file: dv/load_unit_monitor.sv
// Concurrent checks on the load unit pipeline and memory ports
`timescale 1ns/1ps
`include "load_unit_map.vh"
module load_unit_monitor #(
  parameter AW = 32
) (
  input wire          hclk,
  input wire          hresetn,
  input wire          issue_valid,
  input wire [23:0]   issue_instr,
  input wire [31:0]   base_value,
  input wire [1:0]    current_privilege_level,
  input wire          issue_ready,
  input wire          later_mem_hold,
  input wire          rf_write,
  input wire [31:0]   rf_data,
  input wire          exc_valid,
  input wire [5:0]    exc_cause,
  input wire          mem_req,
  input wire [AW-1:0] mem_vaddr,
  input wire          mem_done,
  input wire          mem_error,
  input wire [31:0]   mem_rdata,
  input wire          irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Decode of the accepted instruction
  wire       acc  = issue_valid && issue_ready;
  wire       lsai = issue_instr[3:0] == `OP0_LSAI;
  wire [3:0] r    = issue_instr[15:12];
  wire       wrd  = lsai && (r == `R_WORD_INDEXED || r == `R_WORD_ACQUIRE);
  wire       win  = issue_instr[3:0] == `OP0_QRST && issue_instr[19:16] == `OP1_WINDOW_LOAD;
  reg        last_half;
  reg        last_word;
  // Remember the kind of load in flight for the write-back checks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_half <= 1'b0;
      last_word <= 1'b0;
    end else if (acc) begin
      last_half <= lsai && r == `R_HALF_UNSIGNED;
      last_word <= wrd;
    end
  end
  chk_half_zero_fill:
    assert property (rf_write && last_half |-> rf_data[31:16] == 16'h0) else $error("half upper");
  chk_word_data:
    assert property (rf_write && last_word |-> rf_data == $past(mem_rdata)) else $error("word data");
  chk_half_offset:
    assert property (acc && lsai && r == `R_HALF_UNSIGNED |=> exc_valid || mem_vaddr ==
      (($past(base_value) + {23'h0, $past(issue_instr[23:16]), 1'b0}) & 32'hfffffffe))
      else $error("half address");
  chk_word_offset:
    assert property (acc && wrd |=> exc_valid || mem_vaddr ==
      (($past(base_value) + {22'h0, $past(issue_instr[23:16]), 2'b00}) & 32'hfffffffc))
      else $error("word address");
  chk_window_offset:
    assert property (acc && win && current_privilege_level == 2'd0 |=> exc_valid || mem_vaddr ==
      (($past(base_value) + {26'h3ffffff, $past(r), 2'b00}) & 32'hfffffffc))
      else $error("window address");
  chk_priv_first:
    assert property (acc && win && current_privilege_level != 2'd0 |=> exc_valid && !mem_req)
      else $error("privilege not first");
  chk_error_no_write:
    assert property (mem_done && mem_error |=> exc_valid && exc_cause == `CAUSE_LOAD_ERROR
      && !rf_write) else $error("error path");
  chk_error_no_hold:
    assert property (mem_done && mem_error |=> !later_mem_hold) else $error("hold on error");
  chk_hold_blocks:
    assert property (later_mem_hold |-> !issue_ready && !mem_req) else $error("hold leak");
  cover property (acc && win);
  cover property (mem_done && mem_error);
  cover property (later_mem_hold);
  cover property (irq);
endmodule // load_unit_monitor
bind word_load_execute_unit load_unit_monitor #(.AW(AW)) mon (.*);

// file: dv/mem_partner_model.sv
// Memory subsystem model on the far side of the load unit
`timescale 1ns/1ps
module mem_partner_model (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        mem_req,
  input  wire [31:0] mem_vaddr,
  input  wire [3:0]  lat,
  input  wire [31:0] err_addr,
  input  wire        busy_other,
  output reg         mem_done,
  output reg         mem_error,
  output reg  [31:0] mem_rdata,
  output wire        mem_idle
);
  reg [3:0] cnt;
  // Idle only when no access of ours or of another master is pending
  assign mem_idle = !mem_req && !busy_other && !mem_done;
  // Answer lat+1 cycles after the request; read data toggles outside the done cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_done  <= 1'b0;
      mem_error <= 1'b0;
      mem_rdata <= 32'h0;
      cnt       <= 4'h0;
    end else if (mem_done || !mem_req) begin
      mem_done  <= 1'b0;
      mem_error <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt       <= 4'h0;
    end else if (cnt == lat) begin
      mem_done  <= 1'b1;
      mem_error <= (mem_vaddr == err_addr);
      mem_rdata <= {mem_vaddr[15:0] ^ 16'ha5c3, mem_vaddr[31:16]};
    end else begin
      cnt       <= cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_partner_model

// file: dv/word_load_execute_unit_bench.sv
// Self-checking bench for the load execute unit
`timescale 1ns/1ps
`include "load_unit_map.vh"
module word_load_execute_unit_bench;
  reg         hclk, hresetn, hsel, hwrite, issue_valid, busy_other;
  reg  [31:0] haddr, hwdata, base_value, err_addr, g_addr, g_data, q;
  reg  [1:0]  htrans, cpl, spl, g_ring;
  reg  [23:0] issue_instr;
  reg  [5:0]  g_cause;
  reg         g_req, g_exc, g_tr, g_iok;
  wire [31:0] hrdata, rf_data, mem_vaddr, mem_rdata;
  wire        hreadyout, hresp, irq, issue_ready, later_mem_hold, rf_write, exc_valid;
  wire        mem_req, mem_translate, mem_inst_ok, mem_done, mem_error, mem_idle;
  wire [5:0]  exc_cause;
  wire [3:0]  rf_addr;
  wire [1:0]  mem_ring;
  integer     miscompares, cmp_count;
  word_load_execute_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .issue_valid(issue_valid), .issue_instr(issue_instr), .base_value(base_value),
    .current_privilege_level(cpl), .saved_privilege_level(spl), .issue_ready(issue_ready),
    .later_mem_hold(later_mem_hold), .rf_write(rf_write), .rf_addr(rf_addr),
    .rf_data(rf_data), .exc_valid(exc_valid), .exc_cause(exc_cause), .mem_req(mem_req),
    .mem_vaddr(mem_vaddr), .mem_translate(mem_translate), .mem_ring(mem_ring),
    .mem_inst_ok(mem_inst_ok), .mem_done(mem_done), .mem_error(mem_error),
    .mem_rdata(mem_rdata), .mem_idle(mem_idle));
  mem_partner_model mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_vaddr(mem_vaddr), .lat(4'h2), .err_addr(err_addr), .busy_other(busy_other),
    .mem_done(mem_done), .mem_error(mem_error), .mem_rdata(mem_rdata), .mem_idle(mem_idle));
  // 40 MHz core clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  function [31:0] mdata(input [31:0] a);
    mdata = {a[15:0] ^ 16'ha5c3, a[31:16]};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One AHB-Lite single word transfer; read data lands in q
  task bus(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
    end
  endtask
  // Issue one instruction and record what the memory side and write-back showed
  task run(input [23:0] ins, input [31:0] b);
    integer i;
    begin
      @(posedge hclk);
      issue_valid <= 1'b1;
      issue_instr <= ins;
      base_value <= b;
      g_req = 1'b0;
      g_exc = 1'b0;
      @(negedge hclk);
      while (issue_ready !== 1'b1) @(negedge hclk);
      @(posedge hclk);
      issue_valid <= 1'b0;
      for (i = 0; i < 60 && !(g_exc || rf_write === 1'b1); i = i + 1) begin
        @(negedge hclk);
        if (mem_req === 1'b1) begin
          g_req = 1'b1;
          {g_addr, g_ring, g_tr, g_iok} = {mem_vaddr, mem_ring, mem_translate, mem_inst_ok};
        end
        g_exc = (exc_valid === 1'b1);
        {g_cause, g_data} = {exc_cause, rf_data};
      end
    end
  endtask
  task t_loads;
    begin
      bus(`REG_CTRL, 1'b0, 32'h0);
      chk(q, `CTRL_RESET);
      bus(8'h40, 1'b0, 32'h0);
      chk(q, 32'h0);
      run({8'hff, `R_HALF_UNSIGNED, 4'h1, 4'h5, `OP0_LSAI}, 32'h1001);
      chk(g_addr, 32'h11fe);
      chk(g_data, mdata(32'h11fe) & 32'h0000ffff);
      run({8'hff, `R_WORD_INDEXED, 4'h3, 4'h7, `OP0_LSAI}, 32'h2003);
      chk(g_addr, 32'h23fc);
      chk(g_data, mdata(32'h23fc));
      chk({rf_addr, g_iok, g_tr}, 6'h1e);
      bus(`REG_CTRL, 1'b1, 32'h19);
      run({8'h00, `R_WORD_INDEXED, 4'h3, 4'h7, `OP0_LSAI}, 32'h4000);
      chk(g_tr, 1'b1);
    end
  endtask
  task t_acquire;
    begin
      busy_other <= 1'b1;
      run({8'h01, `R_WORD_ACQUIRE, 4'h3, 4'h4, `OP0_LSAI}, 32'h3000);
      chk(g_addr, 32'h3004);
      chk(g_data, mdata(32'h3004));
      chk(later_mem_hold, 1'b1);
      repeat (5) @(negedge hclk);
      chk({later_mem_hold, issue_ready}, 2'b10);
      @(posedge hclk);
      busy_other <= 1'b0;
      repeat (3) @(negedge hclk);
      chk({later_mem_hold, issue_ready}, 2'b01);
      err_addr <= 32'h3008;
      run({8'h02, `R_WORD_ACQUIRE, 4'h3, 4'h4, `OP0_LSAI}, 32'h3000);
      chk({g_exc, g_cause, rf_write}, {1'b1, `CAUSE_LOAD_ERROR, 1'b0});
      chk(later_mem_hold, 1'b0);
      bus(`REG_FAULT_ADDR, 1'b0, 32'h0);
      chk(q, 32'h3008);
    end
  endtask
  task t_window;
    begin
      cpl <= 2'd1;
      spl <= 2'd2;
      run({`OP2_WINDOW_LOAD, `OP1_WINDOW_LOAD, 4'h0, 4'h2, 4'h6, `OP0_QRST}, 32'h100);
      chk({g_exc, g_cause, g_req}, {1'b1, `CAUSE_PRIV, 1'b0});
      cpl <= 2'd0;
      run({`OP2_WINDOW_LOAD, `OP1_WINDOW_LOAD, 4'h0, 4'h2, 4'h6, `OP0_QRST}, 32'h100);
      chk(g_addr, 32'hc0);
      chk(g_ring, 2'd0);
      bus(`REG_CTRL, 1'b1, 32'h1c);
      run({`OP2_WINDOW_LOAD, `OP1_WINDOW_LOAD, 4'hf, 4'h2, 4'h6, `OP0_QRST}, 32'h100);
      chk(g_addr, 32'hfc);
      chk(g_ring, 2'd2);
      chk(g_tr, 1'b1);
    end
  endtask
  task t_options;
    begin
      bus(`REG_CTRL, 1'b1, 32'h1a);
      run({8'h00, `R_WORD_INDEXED, 4'h3, 4'h7, `OP0_LSAI}, 32'h2002);
      chk({g_exc, g_cause, g_req}, {1'b1, `CAUSE_UNALIGNED, 1'b0});
      bus(`REG_INT_MASK, 1'b1, 32'hf);
      bus(`REG_INT_STATUS, 1'b0, 32'h0);
      chk(q, 32'h7);
      chk(irq, 1'b1);
      bus(`REG_INT_STATUS, 1'b1, 32'h7);
      bus(`REG_INT_STATUS, 1'b0, 32'h0);
      chk(q, 32'h0);
      chk({irq, hresp, hreadyout}, 3'b001);
      bus(`REG_CTRL, 1'b1, 32'h00);
      run({8'h00, `R_WORD_ACQUIRE, 4'h3, 4'h7, `OP0_LSAI}, 32'h2000);
      chk({g_exc, g_cause}, {1'b1, `CAUSE_ILLEGAL});
      run({`OP2_WINDOW_LOAD, `OP1_WINDOW_LOAD, 4'h0, 4'h2, 4'h6, `OP0_QRST}, 32'h100);
      chk({g_exc, g_cause}, {1'b1, `CAUSE_ILLEGAL});
    end
  endtask
  task print_verdict;
    begin
      if (miscompares == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Main sequence: reset for three cycles, then the scenarios
  initial begin
    {miscompares, cmp_count} = 0;
    {hresetn, hsel, hwrite, issue_valid, busy_other, htrans, cpl, spl} = 0;
    {haddr, hwdata, base_value, issue_instr} = 0;
    err_addr = 32'hffff_fff0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_loads;
    t_acquire;
    t_window;
    t_options;
    print_verdict;
  end
  // Watchdog: the scenarios need well under 2000 cycles
  initial begin
    #200000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // word_load_execute_unit_bench

// file: rtl/load_unit_map.vh
// Field positions, opcodes, register offsets and reset values of the load unit
`ifndef LOAD_UNIT_MAP_VH
`define LOAD_UNIT_MAP_VH
// Instruction encodings (24-bit formats)
`define OP0_LSAI          4'h2
`define OP0_QRST          4'h0
`define R_HALF_UNSIGNED   4'h1
`define R_WORD_INDEXED    4'h2
`define R_WORD_ACQUIRE    4'hb
`define OP1_WINDOW_LOAD   4'h9
`define OP2_WINDOW_LOAD   4'h0
// Register offsets (byte addresses)
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_INT_STATUS    8'h08
`define REG_INT_MASK      8'h0c
`define REG_FAULT_ADDR    8'h10
`define REG_CAUSE         8'h14
// Control bits
`define CTRL_TRANSLATE    0
`define CTRL_UNALIGNED    1
`define CTRL_MMU          2
`define CTRL_SYNC_OPT     3
`define CTRL_WINDOW_OPT   4
`define CTRL_RESET        5'h18
// Interrupt status bits
`define INT_LOAD_ERROR    0
`define INT_PRIV          1
`define INT_UNALIGNED     2
`define INT_ILLEGAL       3
`define INT_WIDTH         4
// Cause codes
`define CAUSE_NONE        6'h00
`define CAUSE_ILLEGAL     6'h00
`define CAUSE_PRIV        6'h08
`define CAUSE_UNALIGNED   6'h09
`define CAUSE_LOAD_ERROR  6'h03
`endif

// file: rtl/word_load_execute_unit.v
// Load instruction decode and execute unit with AHB-Lite register access
// Functional notes
// - half unsigned load zero-fills upper sixteen bits
// - half load offset is byte field doubled
// - on error capture address, raise cause, no write
// - acquire load performs before later memory ops
// - hold later memory ops until acquire completes
// - acquire load offset is byte field times four
// - no unaligned option: clear low address bits
// - unaligned option: misaligned load raises exception
// - translate address when translation configured, else identity
// - window load nonzero privilege raises privileged exception
// - window load offset one-extended nibble times four
// - window load checks against saved privilege level
// - without MMU window load uses ring zero
// - indexed word load writes word unchanged
// - indexed word load may access instruction memory
// - acquire decoded only with sync option
// - window load decoded only with window option
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "load_unit_map.vh"

// Register map, one aligned word each:
//   ctrl        translate, unaligned trap, mmu, sync option, window option
//   status      read only: hold, busy, state
//   int_status  sticky events, write one to clear
//   int_mask    enables events onto irq
//   fault addr  last faulting virtual address
//   cause       last exception cause code
// Bus timing: zero wait states, read data registered in the address phase,
// write data taken in the data phase.
// Issue handshake: one instruction in flight; issue_ready drops while the
// memory side works and, after an acquire, until the memory side drains.
// Exceptions are a one-cycle exc_valid pulse the cycle after acceptance,
// or the cycle after mem_done for access errors.
// Limitation: a single outstanding access, so the acquire wait only has
// to cover traffic of other masters, seen through mem_idle.
// Translation is requested when either translate or mmu is set; the
// memory side does the actual mapping and reports errors with mem_done.
// The fault address is the formed address, before the low bits are
// cleared, so software sees what the program asked for.

module word_load_execute_unit #(
  parameter AW = 32
) (
  input  wire          hclk,
  input  wire          hresetn,
  // AHB-Lite slave
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  output reg           irq,
  // Pipeline side
  input  wire          issue_valid,
  input  wire [23:0]   issue_instr,
  input  wire [31:0]   base_value,
  input  wire [1:0]    current_privilege_level,
  input  wire [1:0]    saved_privilege_level,
  output reg           issue_ready,
  output reg           later_mem_hold,
  output reg           rf_write,
  output reg  [3:0]    rf_addr,
  output reg  [31:0]   rf_data,
  output reg           exc_valid,
  output reg  [5:0]    exc_cause,
  // Memory / translation side
  output reg           mem_req,
  output reg  [AW-1:0] mem_vaddr,
  output reg           mem_translate,
  output reg  [1:0]    mem_ring,
  output reg           mem_inst_ok,
  input  wire          mem_done,
  input  wire          mem_error,
  input  wire [31:0]   mem_rdata,
  input  wire          mem_idle
);

  // Execute states
  localparam ST_IDLE = 2'd0;
  localparam ST_MEM  = 2'd1;
  localparam ST_ACQ  = 2'd2;

  // Load kinds carried from decode into the memory state
  localparam K_HALF  = 2'd0;
  localparam K_WORD  = 2'd1;
  localparam K_ACQ   = 2'd2;
  localparam K_WIN   = 2'd3;

  // Scale an offset field into a byte offset
  function [31:0] scaled;
    input [7:0] field;
    input [1:0] shift;
    begin
      scaled = {24'h000000, field} << shift;
    end
  endfunction

  // Register write hit, shared by the writable registers
  function wr_hit;
    input       pend;
    input [7:0] addr;
    input [7:0] offset;
    begin
      wr_hit = pend && (addr == offset);
    end
  endfunction

  // Machine state, captured load kind and software visible registers
  reg  [1:0]  state;
  reg  [1:0]  kind;
  reg  [4:0]  ctrl;
  reg  [3:0]  int_status;
  reg  [3:0]  int_mask;
  reg  [31:0] fault_address_reg;
  reg  [5:0]  cause;
  reg  [31:0] vaddr;

  // Field extraction from fixed positions
  wire [3:0] op0 = issue_instr[3:0];
  wire [3:0] fld_t = issue_instr[7:4];
  wire [3:0] fld_r = issue_instr[15:12];
  wire [3:0] op1 = issue_instr[19:16];
  wire [3:0] op2 = issue_instr[23:20];
  wire [7:0] offset_byte_field = issue_instr[23:16];

  // Decode is combinational on the issue word; the option bits gate the
  // acquire and window forms so a build without them sees them as illegal
  wire lsai = (op0 == `OP0_LSAI);
  wire is_half = lsai && (fld_r == `R_HALF_UNSIGNED);
  wire is_word = lsai && (fld_r == `R_WORD_INDEXED);
  wire is_acq  = lsai && (fld_r == `R_WORD_ACQUIRE) && ctrl[`CTRL_SYNC_OPT];
  wire is_win  = (op0 == `OP0_QRST) && (op1 == `OP1_WINDOW_LOAD) &&
                 (op2 == `OP2_WINDOW_LOAD) && ctrl[`CTRL_WINDOW_OPT];
  wire is_load = is_half | is_word | is_acq | is_win;

  // Address formation per instruction
  reg [31:0] next_vaddr;
  reg [1:0]  next_kind;
  always @* begin
    next_vaddr = base_value + scaled(offset_byte_field, 2'd2);
    next_kind  = K_WORD;
    if (is_half) begin
      next_vaddr = base_value + scaled(offset_byte_field, 2'd1);
      next_kind  = K_HALF;
    end else if (is_acq) begin
      next_kind  = K_ACQ;
    end else if (is_win) begin
      next_vaddr = base_value + {26'h3ffffff, fld_r, 2'b00};
      next_kind  = K_WIN;
    end
  end

  wire misaligned = is_half ? next_vaddr[0] : (next_vaddr[1:0] != 2'b00);
  wire priv_fault = is_win && (current_privilege_level != 2'd0);
  // An instruction is taken on an edge where both sides agree
  wire accept = issue_valid && issue_ready;

  // Address with ignored low bits cleared when unaligned option is off
  wire [31:0] aligned_vaddr = is_half ? {next_vaddr[31:1], 1'b0} :
                              {next_vaddr[31:2], 2'b00};

  // AHB-Lite address phase capture
  // Zero wait states: hreadyout and hresp are constant after reset, so a
  // transfer never stalls and every response is OKAY
  reg        wr_pend;
  reg        rd_pend;
  reg [7:0]  bus_addr;
  wire       bus_go = hsel && hready && htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      bus_addr  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= bus_go && hwrite;
      rd_pend   <= bus_go && !hwrite;
      if (bus_go) begin
        bus_addr <= haddr[7:0];
      end
    end
  end

  // Status word: hold, busy, state
  wire [3:0] status_bits = {later_mem_hold, state == ST_MEM, state};

  // Read data mux; reads are taken in the address phase so hrdata is ready
  // for the data phase
  reg [31:0] next_hrdata;
  always @* begin
    case ({haddr[7:2], 2'b00})
      `REG_CTRL:       next_hrdata = {27'h0, ctrl};
      `REG_STATUS:     next_hrdata = {28'h0, status_bits};
      `REG_INT_STATUS: next_hrdata = {28'h0, int_status};
      `REG_INT_MASK:   next_hrdata = {28'h0, int_mask};
      `REG_FAULT_ADDR: next_hrdata = fault_address_reg;
      `REG_CAUSE:      next_hrdata = {26'h0, cause};
      default:         next_hrdata = 32'h00000000;   // Unmapped reads as zero
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_go && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Events raised by the execute machine, registered so that the sticky
  // bits follow the exception pulse by one cycle
  reg [3:0] event_set;

  // Control register; the options are software visible so one build covers
  // every configuration, at the cost of decode that a fixed build would prune
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_hit(wr_pend, bus_addr, `REG_CTRL)) begin
      ctrl <= hwdata[4:0];
    end
  end

  // Interrupt mask register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask <= 4'h0;
    end else if (wr_hit(wr_pend, bus_addr, `REG_INT_MASK)) begin
      int_mask <= hwdata[3:0];
    end
  end

  // Sticky event bits; a hardware set wins over a write-one clear in the
  // same cycle, so an event that lands during the clear is never lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status <= 4'h0;
    end else if (wr_hit(wr_pend, bus_addr, `REG_INT_STATUS)) begin
      int_status <= (int_status & ~hwdata[3:0]) | event_set;
    end else begin
      int_status <= int_status | event_set;
    end
  end

  // Level interrupt, registered so the pin comes straight from a flip-flop;
  // it trails the status bits by one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  // Execute machine
  //   idle: decode, trap or launch the access in the accept cycle
  //   mem:  hold the request until the memory side answers
  //   acq:  after a clean acquire, keep later traffic back until the
  //         memory side reports idle
  // Traps in idle are checked illegal, privilege, alignment, in that order,
  // so a privileged window load never forms an address
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state             <= ST_IDLE;
      kind              <= K_WORD;
      vaddr             <= 32'h00000000;
      fault_address_reg <= 32'h00000000;
      cause             <= `CAUSE_NONE;
      issue_ready       <= 1'b1;
      later_mem_hold    <= 1'b0;
      rf_write          <= 1'b0;
      rf_addr           <= 4'h0;
      rf_data           <= 32'h00000000;
      exc_valid         <= 1'b0;
      exc_cause         <= `CAUSE_NONE;
      mem_req           <= 1'b0;
      mem_vaddr         <= {AW{1'b0}};
      mem_translate     <= 1'b0;
      mem_ring          <= 2'd0;
      mem_inst_ok       <= 1'b0;
      event_set         <= 4'h0;
    end else begin
      rf_write  <= 1'b0;
      exc_valid <= 1'b0;
      event_set <= 4'h0;
      case (state)
        ST_IDLE: begin
          // Not a load of this unit, or its option is switched off
          if (accept && !is_load) begin
            exc_valid  <= 1'b1;
            exc_cause  <= `CAUSE_ILLEGAL;
            cause      <= `CAUSE_ILLEGAL;
            event_set[`INT_ILLEGAL] <= 1'b1;
          end else if (accept && priv_fault) begin
            // No address formed, no access made
            exc_valid  <= 1'b1;
            exc_cause  <= `CAUSE_PRIV;
            cause      <= `CAUSE_PRIV;
            event_set[`INT_PRIV] <= 1'b1;
          end else if (accept && misaligned && ctrl[`CTRL_UNALIGNED]) begin
            exc_valid  <= 1'b1;
            exc_cause  <= `CAUSE_UNALIGNED;
            cause      <= `CAUSE_UNALIGNED;
            fault_address_reg <= next_vaddr;
            event_set[`INT_UNALIGNED] <= 1'b1;
          end else if (accept) begin
            state         <= ST_MEM;
            issue_ready   <= 1'b0;
            kind          <= next_kind;
            vaddr         <= next_vaddr;
            rf_addr       <= fld_t;
            mem_req       <= 1'b1;
            mem_vaddr     <= aligned_vaddr[AW-1:0];
            mem_translate <= ctrl[`CTRL_TRANSLATE] | ctrl[`CTRL_MMU];
            // Window loads check the saved ring, or ring zero without MMU
            mem_ring      <= is_win ? (ctrl[`CTRL_MMU] ? saved_privilege_level : 2'd0)
                                    : current_privilege_level;
            mem_inst_ok   <= is_word;
          end
        end
        ST_MEM: begin
          if (mem_done) begin
            mem_req <= 1'b0;
            if (mem_error) begin
              fault_address_reg <= vaddr;
              cause       <= `CAUSE_LOAD_ERROR;
              exc_valid   <= 1'b1;
              exc_cause   <= `CAUSE_LOAD_ERROR;
              event_set[`INT_LOAD_ERROR] <= 1'b1;
              state       <= ST_IDLE;
              issue_ready <= 1'b1;
            end else begin
              rf_write <= 1'b1;
              // Half load zero-fills, word loads pass through unchanged
              rf_data  <= (kind == K_HALF) ? {16'h0000, mem_rdata[15:0]}
                                           : mem_rdata;
              if (kind == K_ACQ) begin
                // Ordering wait starts only after a clean completion
                state          <= ST_ACQ;
                later_mem_hold <= 1'b1;
              end else begin
                state       <= ST_IDLE;
                issue_ready <= 1'b1;
              end
            end
          end
        end
        ST_ACQ: begin
          // Memory side must drain before later ops proceed
          if (mem_idle) begin
            state          <= ST_IDLE;
            later_mem_hold <= 1'b0;
            issue_ready    <= 1'b1;
          end
        end
        default: begin
          state       <= ST_IDLE;
          issue_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // word_load_execute_unit
